//--- logic/zoomed_video_router_map.vh
// register offsets, field positions, reset values and timing for the video router
`ifndef ZOOMED_VIDEO_ROUTER_MAP_VH
`define ZOOMED_VIDEO_ROUTER_MAP_VH

// configuration space dword addresses
`define MM_CTRL_ADDR 8'h84
`define GPIO_CTRL_ADDR 8'h88
`define PIN_ROUTE_ADDR 8'h8C

// multimedia video control, byte 0 of dword 84h
`define MM_EN0_BIT 0
`define MM_EN1_BIT 1
`define MM_PRI_LO 2
`define MM_PRI_HI 4
`define MM_AUTO_BIT 5
`define MM_SEL_BIT 6
`define MM_OUTEN_BIT 7
`define MM_CTRL_RESET 8'h00

// multifunction pin routing fields
`define ROUTE_P0_HI 2
`define ROUTE_P0_LO 0
`define ROUTE_P1_HI 6
`define ROUTE_P1_LO 4
`define ROUTE_P2_HI 10
`define ROUTE_P2_LO 8
`define ROUTE_P3_HI 14
`define ROUTE_P3_LO 12
`define ROUTE_P4_HI 18
`define ROUTE_P4_LO 16
`define PIN_ROUTE_RESET 32'h00000000
`define PIN_FN_VIDEO 3'h7

// general-purpose I/O control and router status
`define GPIO_STAT_EN_BIT 0
`define GPIO_OVF_BIT 1
`define GPIO_SRC_LO 4
`define GPIO_ACT_LO 8

// source codes
`define SRC_A 2'h0
`define SRC_B 2'h1
`define SRC_EXT 2'h2

// priority codes
`define PRI_A_B_E 3'h0
`define PRI_A_E_B 3'h1
`define PRI_B_A_E 3'h2
`define PRI_B_E_A 3'h3
`define PRI_E_A_B 3'h4
`define PRI_E_B_A 3'h5
`define PRI_E_B_A2 3'h6

// pixel clock activity window
`define CLK_PERIOD_NS 20
`define ACT_WINDOW_NS 1000
`define ACT_WINDOW_CYC (`ACT_WINDOW_NS / `CLK_PERIOD_NS)
`define ACT_CNT_W 8

// buffering
`define PIX_W 16
`define FIFO_DEPTH 4
`define FIFO_AW 2

`endif

//--- logic/pixel_fifo.v
// small first-in first-out buffer for pixel words
`timescale 1ns/1ps
`default_nettype none

module pixel_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk_in,
	input wire reset_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_ptr;
reg [AW:0] rd_ptr;
wire full;
wire empty;
wire do_wr;
wire do_rd;

// extra pointer bit tells full from empty
assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
assign empty = (wr_ptr == rd_ptr);
assign in_ready_out = ~full;
assign out_valid_out = ~empty;
assign out_data_out = mem[rd_ptr[AW-1:0]];
assign do_wr = in_valid_in & ~full;
assign do_rd = out_ready_in & ~empty;

always @(posedge clk_in) begin
	if (do_wr) begin
		mem[wr_ptr[AW-1:0]] <= in_data_in;
	end
end

always @(posedge clk_in) begin
	if (reset_in) begin
		wr_ptr <= {(AW+1){1'b0}};
		rd_ptr <= {(AW+1){1'b0}};
	end else begin
		if (do_wr) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
		if (do_rd) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
end

endmodule
`default_nettype wire

//--- logic/zoomed_video_router.v
// video source router with pixel clock auto-detect and configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "zoomed_video_router_map.vh"

// What this block does
// - buffered 16-bit pixel path, no external buffers
// - exactly one socket selected, socket 0 at reset
// - output enable drives pins with routed socket pixels; pins not driven while the external source is routed
// - no data unless a socket enable set
// - selected socket disabled: output pins driven low
// - auto-detect senses pixel clocks, switches multiplexer
// - software select bits steer multiplexer directly
// - auto-detect off after reset
// - control bit 5 turns auto-detect on
// - three-bit field orders sources; 111 reserved
// - several active: highest priority source wins
// - routing 111b makes pin 3/2 external clock
// - routing 111b puts switch status on pin 4/1/0
// - status pin also needs general-purpose enable
module zoomed_video_router (
	input wire clk_in,
	input wire reset_in,
	input wire [7:0] cfg_addr_in,
	input wire [3:0] cfg_be_in,
	input wire cfg_write_in,
	input wire cfg_read_in,
	input wire [31:0] cfg_wdata_in,
	output reg [31:0] cfg_rdata_out,
	output reg cfg_rvalid_out,
	input wire socket0_pixel_clk_in,
	input wire [15:0] socket0_pixel_data_in,
	input wire socket1_pixel_clk_in,
	input wire [15:0] socket1_pixel_data_in,
	input wire [4:0] multifunction_pin_in,
	output reg [4:0] multifunction_pin_out,
	output reg [4:0] multifunction_pin_oe_out,
	output reg [15:0] video_data_out,
	output reg video_clk_out,
	output reg video_oe_out
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] multimedia_video_control;
reg [31:0] multifunction_pin_routing;
reg status_pin_enable, overflow;
wire cfg_wr_mm, cfg_wr_gpio, cfg_wr_route, push_drop;
wire socket0_video_enable, socket1_video_enable, auto_detect;
wire output_socket_select, video_output_enable;
wire [2:0] priority_code;
integer b;

assign socket0_video_enable = multimedia_video_control[`MM_EN0_BIT];
assign socket1_video_enable = multimedia_video_control[`MM_EN1_BIT];
assign priority_code = multimedia_video_control[`MM_PRI_HI:`MM_PRI_LO];
assign auto_detect = multimedia_video_control[`MM_AUTO_BIT];
assign output_socket_select = multimedia_video_control[`MM_SEL_BIT];
assign video_output_enable = multimedia_video_control[`MM_OUTEN_BIT];

assign cfg_wr_mm = cfg_write_in & (cfg_addr_in == `MM_CTRL_ADDR) & cfg_be_in[0];
assign cfg_wr_gpio = cfg_write_in & (cfg_addr_in == `GPIO_CTRL_ADDR) & cfg_be_in[0];
assign cfg_wr_route = cfg_write_in & (cfg_addr_in == `PIN_ROUTE_ADDR);

always @(posedge clk_in) begin
	if (reset_in) begin
		// select bit resets to socket 0, auto-detect bit resets clear
		multimedia_video_control <= `MM_CTRL_RESET;
		multifunction_pin_routing <= `PIN_ROUTE_RESET;
		status_pin_enable <= 1'b0;
		overflow <= 1'b0;
	end else begin
		if (cfg_wr_mm) begin
			// bits 7:6 and 5 take effect on the next cycle
			multimedia_video_control <= cfg_wdata_in[7:0];
		end
		if (cfg_wr_route) begin
			for (b = 0; b < 4; b = b + 1) begin
				if (cfg_be_in[b]) begin
					multifunction_pin_routing[8*b +: 8] <= cfg_wdata_in[8*b +: 8];
				end
			end
		end
		if (cfg_wr_gpio) begin
			status_pin_enable <= cfg_wdata_in[`GPIO_STAT_EN_BIT];
		end
		// a new drop beats a clear in the same cycle
		if (push_drop) begin
			overflow <= 1'b1;
		end else if (cfg_wr_gpio & cfg_wdata_in[`GPIO_OVF_BIT]) begin
			overflow <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// pixel clock synchronisers and activity detectors
wire route_p3_clk, route_p2_clk, ext_rise;
wire [3:0] clk_raw, raw_rise;
reg [3:0] clk_s1, clk_s2, clk_s3;
wire [2:0] clk_rise, active;
wire [31:0] act_reload;

assign route_p3_clk = (multifunction_pin_routing[`ROUTE_P3_HI:`ROUTE_P3_LO] == `PIN_FN_VIDEO);
assign route_p2_clk = (multifunction_pin_routing[`ROUTE_P2_HI:`ROUTE_P2_LO] == `PIN_FN_VIDEO);
// each pin has its own synchroniser, so a routing change cannot glitch a sync input
assign clk_raw = {multifunction_pin_in[3:2], socket1_pixel_clk_in, socket0_pixel_clk_in};
assign raw_rise = clk_s2 & ~clk_s3;
// pin 3 wins if software routes both pins as clock inputs
assign ext_rise = route_p3_clk ? raw_rise[3] : (route_p2_clk & raw_rise[2]);
assign clk_rise = {ext_rise, raw_rise[1:0]};
assign act_reload = `ACT_WINDOW_CYC;

always @(posedge clk_in) begin
	if (reset_in) begin
		clk_s1 <= 4'h0;
		clk_s2 <= 4'h0;
		clk_s3 <= 4'h0;
	end else begin
		clk_s1 <= clk_raw;
		clk_s2 <= clk_s1;
		clk_s3 <= clk_s2;
	end
end

genvar g;
generate
	for (g = 0; g < 3; g = g + 1) begin : act_det
		reg [`ACT_CNT_W-1:0] act_cnt;
		always @(posedge clk_in) begin
			if (reset_in) begin
				act_cnt <= {`ACT_CNT_W{1'b0}};
			end else if (clk_rise[g]) begin
				// each edge rearms the window, so a slow clock stays active
				act_cnt <= act_reload[`ACT_CNT_W-1:0];
			end else if (act_cnt != {`ACT_CNT_W{1'b0}}) begin
				act_cnt <= act_cnt - 1'b1;
			end
		end
		assign active[g] = (act_cnt != {`ACT_CNT_W{1'b0}});
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// source selection
// returns {found, source}; order packs highest priority in the low slot
function [2:0] pick_source;
	input [2:0] code;
	input [2:0] act;
	reg [5:0] order;
	integer i;
	begin
		case (code)
			`PRI_A_B_E: order = {`SRC_EXT, `SRC_B, `SRC_A};
			`PRI_A_E_B: order = {`SRC_B, `SRC_EXT, `SRC_A};
			`PRI_B_A_E: order = {`SRC_EXT, `SRC_A, `SRC_B};
			`PRI_B_E_A: order = {`SRC_A, `SRC_EXT, `SRC_B};
			`PRI_E_A_B: order = {`SRC_B, `SRC_A, `SRC_EXT};
			`PRI_E_B_A: order = {`SRC_A, `SRC_B, `SRC_EXT};
			`PRI_E_B_A2: order = {`SRC_A, `SRC_B, `SRC_EXT};
			// reserved code falls back to the first order
			default: order = {`SRC_EXT, `SRC_B, `SRC_A};
		endcase
		pick_source = 3'h0;
		// walk lowest rank first so the highest active rank is written last
		for (i = 2; i >= 0; i = i - 1) begin
			if (act[order[2*i +: 2]]) begin
				pick_source = {1'b1, order[2*i +: 2]};
			end
		end
	end
endfunction

wire [2:0] auto_pick;
reg [1:0] route_src, next_route_src;

assign auto_pick = pick_source(priority_code, active);

always @* begin
	if (auto_detect & auto_pick[2]) begin
		next_route_src = auto_pick[1:0];
	end else begin
		// manual mode, or nothing active while auto-detect is on
		next_route_src = {1'b0, output_socket_select};
	end
end

always @(posedge clk_in) begin
	if (reset_in) begin
		route_src <= `SRC_A;
	end else begin
		route_src <= next_route_src;
	end
end

////////////////////////////////////////////////////////////////////////////////
// capture into the internal buffer
reg [15:0] data0_s1, data0_s2, data1_s1, data1_s2;
wire src_is_ext, src_enabled, path_on;
wire push_valid, push_ready, pop_valid, pop_ready;
wire [15:0] push_data, pop_data;

always @(posedge clk_in) begin
	if (reset_in) begin
		data0_s1 <= 16'h0000;
		data0_s2 <= 16'h0000;
		data1_s1 <= 16'h0000;
		data1_s2 <= 16'h0000;
	end else begin
		data0_s1 <= socket0_pixel_data_in;
		data0_s2 <= data0_s1;
		data1_s1 <= socket1_pixel_data_in;
		data1_s2 <= data1_s1;
	end
end

assign src_is_ext = (route_src == `SRC_EXT);
assign src_enabled = (route_src == `SRC_A) ? socket0_video_enable :
	(route_src == `SRC_B) ? socket1_video_enable : 1'b0;
// disabled socket or no socket enabled means nothing leaves the port
assign path_on = video_output_enable & src_enabled;
assign push_valid = path_on & clk_rise[route_src];
assign push_data = (route_src == `SRC_B) ? data1_s2 : data0_s2;
// the drain side cannot keep up only if a source clocks faster than a third of ours
assign push_drop = push_valid & ~push_ready;

pixel_fifo #(
	.WIDTH(`PIX_W),
	.DEPTH(`FIFO_DEPTH),
	.AW(`FIFO_AW)
) pixel_buffer (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.in_valid_in(push_valid),
	.in_ready_out(push_ready),
	.in_data_in(push_data),
	.out_valid_out(pop_valid),
	.out_ready_in(pop_ready),
	.out_data_out(pop_data)
);

////////////////////////////////////////////////////////////////////////////////
// output stage: data set up one cycle before the clock rises
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_SETUP = 3'b010;
localparam [2:0] ST_HIGH = 3'b100;
reg [2:0] out_state, next_out_state;

// a closed path drains stale words so a reopened path starts fresh
assign pop_ready = (out_state == ST_IDLE) | ~path_on;

always @* begin
	case (out_state)
		ST_IDLE: next_out_state = (path_on & pop_valid) ? ST_SETUP : ST_IDLE;
		ST_SETUP: next_out_state = path_on ? ST_HIGH : ST_IDLE;
		ST_HIGH: next_out_state = ST_IDLE;
		default: next_out_state = ST_IDLE;
	endcase
end

always @(posedge clk_in) begin
	if (reset_in) begin
		out_state <= ST_IDLE;
		video_data_out <= 16'h0000;
		video_clk_out <= 1'b0;
		video_oe_out <= 1'b0;
	end else begin
		out_state <= next_out_state;
		// external source drives the port through its own buffers
		video_oe_out <= video_output_enable & ~src_is_ext;
		if (~path_on) begin
			video_data_out <= 16'h0000;
			video_clk_out <= 1'b0;
		end else begin
			if (out_state == ST_IDLE && pop_valid) begin
				video_data_out <= pop_data;
			end
			video_clk_out <= (next_out_state == ST_HIGH);
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// switch status onto multifunction pins, register reads
wire [4:0] status_route;

assign status_route[0] = (multifunction_pin_routing[`ROUTE_P0_HI:`ROUTE_P0_LO] == `PIN_FN_VIDEO);
assign status_route[1] = (multifunction_pin_routing[`ROUTE_P1_HI:`ROUTE_P1_LO] == `PIN_FN_VIDEO);
assign status_route[2] = 1'b0;
assign status_route[3] = 1'b0;
assign status_route[4] = (multifunction_pin_routing[`ROUTE_P4_HI:`ROUTE_P4_LO] == `PIN_FN_VIDEO);

always @(posedge clk_in) begin
	if (reset_in) begin
		multifunction_pin_out <= 5'h00;
		multifunction_pin_oe_out <= 5'h00;
	end else begin
		// needs both the routing code and the general-purpose enable
		multifunction_pin_oe_out <= status_route & {5{status_pin_enable}};
		// high while the external source owns the port, for its buffers
		multifunction_pin_out <= status_route & {5{status_pin_enable & src_is_ext}};
	end
end

always @(posedge clk_in) begin
	if (reset_in) begin
		cfg_rdata_out <= 32'h00000000;
		cfg_rvalid_out <= 1'b0;
	end else begin
		cfg_rvalid_out <= cfg_read_in;
		if (cfg_read_in) begin
			case (cfg_addr_in)
				`MM_CTRL_ADDR: cfg_rdata_out <= {24'h000000, multimedia_video_control};
				`PIN_ROUTE_ADDR: cfg_rdata_out <= multifunction_pin_routing;
				`GPIO_CTRL_ADDR: begin
					cfg_rdata_out <= 32'h00000000;
					cfg_rdata_out[`GPIO_STAT_EN_BIT] <= status_pin_enable;
					cfg_rdata_out[`GPIO_OVF_BIT] <= overflow;
					cfg_rdata_out[`GPIO_SRC_LO +: 2] <= route_src;
					cfg_rdata_out[`GPIO_ACT_LO +: 3] <= active;
				end
				default: cfg_rdata_out <= 32'h00000000;
			endcase
		end
	end
end

endmodule
`default_nettype wire

//--- bench/zoomed_video_router_assertions.sv
// concurrent checks on the video router ports
`timescale 1ns/1ps
`default_nettype none
`include "zoomed_video_router_map.vh"
module zoomed_video_router_checker (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic cfg_write_in,
	input wire logic cfg_read_in,
	input wire logic [31:0] cfg_wdata_in,
	input wire logic cfg_rvalid_out,
	input wire logic socket0_pixel_clk_in,
	input wire logic [4:0] multifunction_pin_oe_out,
	input wire logic [15:0] video_data_out,
	input wire logic video_clk_out,
	input wire logic video_oe_out
);
	logic [7:0] ctrl;
	logic [2:0] route0;
	logic gpen;
	logic [2:0] stab;
	wire steady = (stab == 3'h7);
	wire open0 = ctrl[7] && !ctrl[6] && !ctrl[5] && ctrl[0];
	wire stat_ok = (route0 == 3'h7) && gpen;
	// shadow of the control registers; stab waits out seven quiet cycles after any configuration write
	always @(posedge clk_in) begin
		if (reset_in) begin
			ctrl <= 8'h00;
			route0 <= 3'h0;
			gpen <= 1'b0;
			stab <= 3'h0;
		end else begin
			if (cfg_write_in && cfg_addr_in == `MM_CTRL_ADDR && cfg_be_in[0]) ctrl <= cfg_wdata_in[7:0];
			if (cfg_write_in && cfg_addr_in == `PIN_ROUTE_ADDR && cfg_be_in[0]) route0 <= cfg_wdata_in[2:0];
			if (cfg_write_in && cfg_addr_in == `GPIO_CTRL_ADDR && cfg_be_in[0]) gpen <= cfg_wdata_in[0];
			stab <= cfg_write_in ? 3'h0 : (steady ? stab : stab + 3'h1);
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence word_gap;
		##1 !video_clk_out [*2];
	endsequence
	sequence pix0_rise;
		$rose(socket0_pixel_clk_in) && open0 && steady;
	endsequence
	reset_quiet_a: assert property ($fell(reset_in) |-> !video_oe_out && video_data_out == 16'h0000
		&& !video_clk_out && multifunction_pin_oe_out == 5'h00) else $error("outputs busy after reset");
	read_answer_a: assert property (cfg_read_in |=> cfg_rvalid_out) else $error("read unanswered");
	no_enable_a: assert property (steady && !ctrl[0] && !ctrl[1] |-> video_data_out == 16'h0000
		&& !video_clk_out) else $error("data with no socket enabled");
	off_socket_a: assert property (steady && !ctrl[5] && !(ctrl[6] ? ctrl[1] : ctrl[0])
		|-> video_data_out == 16'h0000 && !video_clk_out) else $error("disabled socket passed data");
	outen_drive_a: assert property (steady && !ctrl[5] |-> video_oe_out == ctrl[7])
		else $error("output enable does not follow control");
	word_gap_a: assert property (video_clk_out |-> word_gap) else $error("pixel strobe too close");
	pixel_path_a: assert property (pix0_rise |-> ##[2:8] video_clk_out)
		else $error("socket 0 word not forwarded");
	status_pin_a: assert property (multifunction_pin_oe_out[0] |-> $past(stat_ok))
		else $error("status pin driven without routing");
endmodule
bind zoomed_video_router zoomed_video_router_checker chk (.clk_in(clk_in), .reset_in(reset_in),
	.cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_write_in(cfg_write_in),
	.cfg_read_in(cfg_read_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rvalid_out(cfg_rvalid_out),
	.socket0_pixel_clk_in(socket0_pixel_clk_in), .multifunction_pin_oe_out(multifunction_pin_oe_out),
	.video_data_out(video_data_out), .video_clk_out(video_clk_out), .video_oe_out(video_oe_out));
`default_nettype wire

//--- bench/video_source.sv
// behavioural pixel source standing in for a card or the board source
`timescale 1ns/1ps
`default_nettype none
module video_source #(
	parameter logic [7:0] TAG = 8'hA0,
	parameter int PHASE = 0
) (
	input wire logic run_in,
	input wire logic bus_en_in,
	output logic pix_clk_out,
	output wire logic [15:0] pix_data_out
);
	logic [7:0] cnt = 8'h00;
	logic [15:0] held = 16'h0000;
	// board buffers closed: the line no longer shows a valid word
	assign pix_data_out = bus_en_in ? held : ~held;
	// clock stands still when stopped; data moves on the falling edge for hold margin
	initial begin
		pix_clk_out = 1'b0;
		#PHASE;
		forever begin
			#80;
			if (run_in) begin
				pix_clk_out = ~pix_clk_out;
				if (!pix_clk_out) cnt = cnt + 8'h01;
				held = {TAG, cnt};
			end else begin
				pix_clk_out = 1'b0;
				held = ~held;
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the video router
`timescale 1ns/1ps
`default_nettype none
`include "zoomed_video_router_map.vh"
module testbench;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] cfg_addr_in = 8'h00;
	logic [3:0] cfg_be_in = 4'h0;
	logic cfg_write_in = 1'b0;
	logic cfg_read_in = 1'b0;
	logic [31:0] cfg_wdata_in = 32'h00000000;
	logic [31:0] cfg_rdata_out, rd;
	logic cfg_rvalid_out, video_clk_out, video_oe_out;
	logic [2:0] run = 3'h0;
	logic [2:0] pclk;
	logic [15:0] pd0, pd1, pd2, video_data_out;
	logic [4:0] pin_out, pin_oe, pin_in;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	always #10 clk_in = ~clk_in;
	// the board source's clock reaches both clock-capable pins; routing picks one
	assign pin_in = {1'b0, pclk[2], pclk[2], 2'b00};
	// a card drives its pixel bus only while it streams
	video_source #(.TAG(8'hA0), .PHASE(3)) src0 (.run_in(run[0]), .bus_en_in(run[0]),
		.pix_clk_out(pclk[0]), .pix_data_out(pd0));
	video_source #(.TAG(8'hB0), .PHASE(37)) src1 (.run_in(run[1]), .bus_en_in(run[1]),
		.pix_clk_out(pclk[1]), .pix_data_out(pd1));
	video_source #(.TAG(8'hE0), .PHASE(61)) src2 (.run_in(run[2]), .bus_en_in(pin_out[0]),
		.pix_clk_out(pclk[2]), .pix_data_out(pd2));
	zoomed_video_router dut (.clk_in(clk_in), .reset_in(reset_in), .cfg_addr_in(cfg_addr_in),
		.cfg_be_in(cfg_be_in), .cfg_write_in(cfg_write_in), .cfg_read_in(cfg_read_in),
		.cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
		.socket0_pixel_clk_in(pclk[0]), .socket0_pixel_data_in(pd0),
		.socket1_pixel_clk_in(pclk[1]), .socket1_pixel_data_in(pd1),
		.multifunction_pin_in(pin_in), .multifunction_pin_out(pin_out),
		.multifunction_pin_oe_out(pin_oe), .video_data_out(video_data_out),
		.video_clk_out(video_clk_out), .video_oe_out(video_oe_out));
	////////////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge clk_in);
		{cfg_addr_in, cfg_be_in, cfg_wdata_in, cfg_write_in} = {a, be, d, 1'b1};
		@(negedge clk_in);
		cfg_write_in = 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(negedge clk_in);
		{cfg_addr_in, cfg_read_in} = {a, 1'b1};
		@(negedge clk_in);
		cfg_read_in = 1'b0;
		@(negedge clk_in);
		rd = cfg_rdata_out;
	endtask
	task grab(output logic [15:0] w);
		int k;
		k = 0;
		do begin
			@(negedge clk_in);
			k++;
		end while (video_clk_out !== 1'b1 && k < 40);
		check("word strobe", 32'h1, {31'h0, video_clk_out});
		w = video_data_out;
	endtask
	// the first words after a switch may still be the old source's, so let them pass
	task stream(input logic [7:0] tag);
		logic [15:0] a, b;
		repeat (30) @(negedge clk_in);
		grab(a);
		grab(b);
		check("word source", {24'h0, tag}, {24'h0, a[15:8]});
		check("word order", {24'h0, a[7:0] + 8'h01}, {24'h0, b[7:0]});
	endtask
	// the caller samples after this wait, so the value judged is the settled one
	task settle;
		repeat (30) @(negedge clk_in);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		rdr(`MM_CTRL_ADDR);
		check("ctrl reset", {24'h0, `MM_CTRL_RESET}, rd);
		rdr(`PIN_ROUTE_ADDR);
		check("route reset", `PIN_ROUTE_RESET, rd);
		wr(8'h90, 4'hF, 32'hFFFFFFFF);
		rdr(8'h90);
		check("unmapped", 32'h0, rd);
	endtask
	task t_manual;
		run = 3'b011;
		wr(`MM_CTRL_ADDR, 4'h1, 32'hC1);
		settle;
		check("closed data", 32'h0, {16'h0, video_data_out});
		wr(`MM_CTRL_ADDR, 4'h1, 32'h83);
		stream(8'hA0);
		wr(`MM_CTRL_ADDR, 4'h1, 32'hC3);
		stream(8'hB0);
		wr(`MM_CTRL_ADDR, 4'h1, 32'h43);
		settle;
		check("oe off", 32'h0, {31'h0, video_oe_out});
		wr(`MM_CTRL_ADDR, 4'h1, 32'hC0);
		settle;
		check("no enable", 32'h0, {16'h0, video_data_out});
	endtask
	// winner per priority code, two bits a code: with and without the board source
	task t_auto;
		logic [15:0] tbl;
		int e, c;
		run = 3'b111;
		wr(`PIN_ROUTE_ADDR, 4'h3, 32'h7007);
		wr(`GPIO_CTRL_ADDR, 4'h1, 32'h1);
		for (e = 1; e >= 0; e--) begin
			tbl = e ? 16'h2A50 : 16'h1450;
			run[2] = e[0];
			repeat (80) @(negedge clk_in);
			for (c = 0; c < 8; c++) begin
				wr(`MM_CTRL_ADDR, 4'h1, 32'hA3 | (c << 2));
				repeat (10) @(negedge clk_in);
				rdr(`GPIO_CTRL_ADDR);
				check("routed source", {30'h0, tbl[2*c +: 2]}, {30'h0, rd[5:4]});
				check("status pin", {31'h0, tbl[2*c +: 2] == 2'h2}, {31'h0, pin_out[0]});
				check("status pin drive", 32'h1, {31'h0, pin_oe[0]});
				if (e == 1 && c == 0) check("active flags", 32'h7, {29'h0, rd[10:8]});
			end
		end
		stream(8'hA0);
	endtask
	task t_fallback;
		run = 3'b000;
		wr(`MM_CTRL_ADDR, 4'h1, 32'hE3);
		repeat (80) @(negedge clk_in);
		rdr(`GPIO_CTRL_ADDR);
		check("fallback source", 32'h1, {30'h0, rd[5:4]});
		check("idle flags", 32'h0, {29'h0, rd[10:8]});
		wr(`PIN_ROUTE_ADDR, 4'h3, 32'h0700);
		run = 3'b100;
		repeat (80) @(negedge clk_in);
		rdr(`GPIO_CTRL_ADDR);
		check("pin 2 clock", 32'h4, {29'h0, rd[10:8]});
		check("pin 2 source", 32'h2, {30'h0, rd[5:4]});
	endtask
	task close_out;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			close_out;
		end
	end
	initial begin
		repeat (5) @(posedge clk_in);
		@(negedge clk_in);
		reset_in = 1'b0;
		t_reset;
		t_manual;
		t_auto;
		t_fallback;
		close_out;
	end
endmodule
`default_nettype wire
